/* breaker_failure_defines.svh */
// Constants of the breaker failure scheme.
// Notes on behaviour
// - Selected protection trip input starts the scheme.
// - Seal-in holds only while current exceeds supervision.
// - Optional current check gates accepted initiation.
// - Seal-in option latches only above supervision level.
// - Valid initiation re-trips the breaker at once.
// - Three enabled delayed paths declare zone trip.
// - Early path: delay, fast contact closed, current.
// - Main path: delay and current, no contacts.
// - Early/main expiry enables high detector, starts switch timer.
// - Slow path: contact, in-service, no current check.
// - Each path works only when enabled.
// - Zone trip held for programmable dropout period.
// - Current detectors reset well within 0.7 cycle.
// - Mode selects single-pole or three-pole operation.
// - Neutral supervision only in three-pole mode.
// - Stage status, target and trip indicator outputs.
// - Delays 0 to 65.535 s in 1 ms steps.
// - Pickup levels 0.001 to 30.000 pu.
// - Low detector takes over after its delay.
`ifndef BREAKER_FAILURE_DEFINES_SVH
`define BREAKER_FAILURE_DEFINES_SVH

`define TIME_W            16
`define LEVEL_W           15
`define CURRENT_W         16
`define TICK_CNT_W        17
`define CLK_PERIOD_NS     10
`define TICK_PERIOD_US    1000
`define TICK_CYCLES       ((`TICK_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define SYNC_W            5
`define SYNC_START        0
`define SYNC_FAST_AUX     1
`define SYNC_NORMAL_AUX   2
`define SYNC_OUT_SERVICE  3
`define SYNC_INHIBIT      4
`define SYNC_RST          5'h00
`define TIME_RST          16'h0000
`define TICK_CNT_RST      17'h00000
`define FLAG_RST          1'b0

`endif

/* breaker_failure_pkg.sv */
// Types shared by the breaker failure scheme modules.
`include "breaker_failure_defines.svh"

package breaker_failure_pkg;

  typedef enum logic [0:0]
  {
    POLE_SINGLE = 1'b0,
    POLE_THREE  = 1'b1
  } pole_mode_t;

  typedef struct packed
  {
    logic [`CURRENT_W-1:0] phase_a;
    logic [`CURRENT_W-1:0] phase_b;
    logic [`CURRENT_W-1:0] phase_c;
    logic [`CURRENT_W-1:0] neutral;
  } currents_t;

  typedef struct packed
  {
    logic                scheme_function_en;
    pole_mode_t          failure_pole_mode;
    logic                initiate_current_check_en;
    logic                latch_current_check_en;
    logic                early_path_en;
    logic                main_path_en;
    logic                slow_path_en;
    logic [`LEVEL_W-1:0] phase_supervision_level;
    logic [`LEVEL_W-1:0] neutral_supervision_level;
    logic [`LEVEL_W-1:0] phase_high_level;
    logic [`LEVEL_W-1:0] neutral_high_level;
    logic [`LEVEL_W-1:0] phase_low_level;
    logic [`LEVEL_W-1:0] neutral_low_level;
    logic [`TIME_W-1:0]  early_path_delay;
    logic [`TIME_W-1:0]  main_path_delay;
    logic [`TIME_W-1:0]  slow_path_delay;
    logic [`TIME_W-1:0]  low_level_switch_delay;
    logic [`TIME_W-1:0]  trip_hold_period;
  } scheme_settings_t;

  typedef struct packed
  {
    logic initiated;
    logic sealed;
    logic early_op;
    logic main_op;
    logic slow_op;
    logic high_level_active;
    logic low_level_active;
  } scheme_status_t;

  typedef struct packed
  {
    logic above;
  } level_state_t;

  typedef struct packed
  {
    logic [`TIME_W-1:0] count;
    logic               done;
  } timer_state_t;

  typedef struct packed
  {
    logic [`SYNC_W-1:0]     sync_first;
    logic [`SYNC_W-1:0]     sync_second;
    logic [`TICK_CNT_W-1:0] tick_count;
    logic                   tick;
    logic                   seal;
    logic                   retrip;
    logic                   trip;
    logic                   target;
    logic                   trip_led;
    scheme_status_t         status;
  } scheme_state_t;

endpackage : breaker_failure_pkg

/* level_detect.sv */
// Registered current level detector over three phases, plus neutral in three-pole mode.
`timescale 1ns/100ps
`include "breaker_failure_defines.svh"

module level_detect
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // Measurement and thresholds
  input  wire breaker_failure_pkg::currents_t currents,
  input  wire logic [`LEVEL_W-1:0]            phase_level,
  input  wire logic [`LEVEL_W-1:0]            neutral_level,
  input  wire breaker_failure_pkg::pole_mode_t pole_mode,
  // Result
  output logic                               above
);

  breaker_failure_pkg::level_state_t state_reg;
  breaker_failure_pkg::level_state_t state_next;
  logic [`CURRENT_W-1:0]             phase_ref;
  logic [`CURRENT_W-1:0]             neutral_ref;

  assign phase_ref   = {1'b0, phase_level};
  assign neutral_ref = {1'b0, neutral_level};

  always_comb
  begin
    state_next = state_reg;
    // One-clock reset.
    // The decision is remade every clock, so it drops out within one clock period.
    state_next.above = (currents.phase_a > phase_ref) || (currents.phase_b > phase_ref)
                    || (currents.phase_c > phase_ref)
                    || ((pole_mode == breaker_failure_pkg::POLE_THREE)
                        && (currents.neutral > neutral_ref));
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= '{above: `FLAG_RST};
    else
      state_reg <= state_next;
  end

  assign above = state_reg.above;

endmodule : level_detect

/* pickup_timer.sv */
// Pickup timer counting protection ticks while its run input holds.
`timescale 1ns/100ps
`include "breaker_failure_defines.svh"

module pickup_timer
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Control
  input  wire logic               tick,
  input  wire logic               run,
  input  wire logic [`TIME_W-1:0] delay,
  // Result
  output logic                    done
);

  breaker_failure_pkg::timer_state_t state_reg;
  breaker_failure_pkg::timer_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    // Tick based count.
    // Dropping run restarts the delay from zero, like a definite-time element.
    if (!run)
    begin
      state_next.count = `TIME_RST;
      state_next.done  = 1'b0;
    end
    else if (state_reg.count >= delay)
      state_next.done = 1'b1;
    else if (tick)
      state_next.count = state_reg.count + 16'h0001;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= '{count: `TIME_RST, done: `FLAG_RST};
    else
      state_reg <= state_next;
  end

  assign done = state_reg.done;

endmodule : pickup_timer

/* breaker_failure_scheme.sv */
// Breaker failure scheme: initiation, delayed failure paths and trip output.
`timescale 1ns/100ps
`include "breaker_failure_defines.svh"

module breaker_failure_scheme
#(
  parameter logic [`TICK_CNT_W-1:0] TICK_CYCLES = `TICK_CNT_W'(`TICK_CYCLES)
)
(
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  // Settings
  input  wire breaker_failure_pkg::scheme_settings_t settings,
  // Measured current magnitudes
  input  wire breaker_failure_pkg::currents_t        currents,
  // Scheme inputs from protection and breaker
  input  wire logic                                 three_pole_start_input,
  input  wire logic                                 fast_aux_closed,
  input  wire logic                                 normal_aux_closed,
  input  wire logic                                 out_of_service_input,
  input  wire logic                                 scheme_inhibit_input,
  // Scheme outputs
  output logic                                      retrip,
  output logic                                      zone_trip,
  output logic                                      failure_target,
  output logic                                      trip_indicator,
  output breaker_failure_pkg::scheme_status_t        status
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  breaker_failure_pkg::scheme_state_t state_reg;
  breaker_failure_pkg::scheme_state_t state_next;

  logic [`SYNC_W-1:0] pins;
  logic               start_in;
  logic               fast_aux;
  logic               normal_aux;
  logic               out_service;
  logic               block;
  logic               supervision_ok;
  logic               high_above;
  logic               low_above;
  logic               initiated;
  logic               active;
  logic               early_done;
  logic               main_done;
  logic               slow_done;
  logic               low_switch_done;
  logic               hold_done;
  logic               high_enabled;
  logic               fault_current;
  logic               early_op;
  logic               main_op;
  logic               slow_op;
  logic               trip_cause;

  // ****************************************************************
  // Input synchronisers and qualification
  // ****************************************************************

  assign pins[`SYNC_START]       = three_pole_start_input;
  assign pins[`SYNC_FAST_AUX]    = fast_aux_closed;
  assign pins[`SYNC_NORMAL_AUX]  = normal_aux_closed;
  assign pins[`SYNC_OUT_SERVICE] = out_of_service_input;
  assign pins[`SYNC_INHIBIT]     = scheme_inhibit_input;

  assign start_in    = state_reg.sync_second[`SYNC_START];
  assign fast_aux    = state_reg.sync_second[`SYNC_FAST_AUX];
  assign normal_aux  = state_reg.sync_second[`SYNC_NORMAL_AUX];
  assign out_service = state_reg.sync_second[`SYNC_OUT_SERVICE];

  assign block = state_reg.sync_second[`SYNC_INHIBIT] || !settings.scheme_function_en;

  // ****************************************************************
  // Current detectors
  // ****************************************************************

  level_detect supervision_detect
  (
    .clk           (clk),
    .reset_n       (reset_n),
    .currents      (currents),
    .phase_level   (settings.phase_supervision_level),
    .neutral_level (settings.neutral_supervision_level),
    .pole_mode     (settings.failure_pole_mode),
    .above         (supervision_ok)
  );

  level_detect high_detect
  (
    .clk           (clk),
    .reset_n       (reset_n),
    .currents      (currents),
    .phase_level   (settings.phase_high_level),
    .neutral_level (settings.neutral_high_level),
    .pole_mode     (settings.failure_pole_mode),
    .above         (high_above)
  );

  level_detect low_detect
  (
    .clk           (clk),
    .reset_n       (reset_n),
    .currents      (currents),
    .phase_level   (settings.phase_low_level),
    .neutral_level (settings.neutral_low_level),
    .pole_mode     (settings.failure_pole_mode),
    .above         (low_above)
  );

  // ****************************************************************
  // Initiation
  // ****************************************************************

  assign initiated = !block && start_in
                  && (!settings.initiate_current_check_en || supervision_ok);
  assign active    = initiated || (state_reg.seal && !block);

  // ****************************************************************
  // Failure path timers
  // ****************************************************************

  pickup_timer early_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (state_reg.tick),
    .run     (active && settings.early_path_en),
    .delay   (settings.early_path_delay),
    .done    (early_done)
  );

  pickup_timer main_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (state_reg.tick),
    .run     (active && settings.main_path_en),
    .delay   (settings.main_path_delay),
    .done    (main_done)
  );

  pickup_timer slow_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (state_reg.tick),
    .run     (active && settings.slow_path_en),
    .delay   (settings.slow_path_delay),
    .done    (slow_done)
  );

  assign high_enabled = (early_done && settings.early_path_en)
                     || (main_done && settings.main_path_en);

  pickup_timer low_switch_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (state_reg.tick),
    .run     (active && high_enabled),
    .delay   (settings.low_level_switch_delay),
    .done    (low_switch_done)
  );

  // Low level takeover.
  // The low detector alone would miss nothing, but would trip on resistor current too early.
  assign fault_current = low_switch_done ? low_above : high_above;

  assign early_op = active && settings.early_path_en && early_done && fast_aux
                 && fault_current;
  assign main_op  = active && settings.main_path_en && main_done && fault_current;
  assign slow_op  = active && settings.slow_path_en && slow_done && normal_aux
                 && !out_service;
  assign trip_cause = early_op || main_op || slow_op;

  pickup_timer hold_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (state_reg.tick),
    .run     (state_reg.trip && !trip_cause && !block),
    .delay   (settings.trip_hold_period),
    .done    (hold_done)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb
  begin
    state_next             = state_reg;
    state_next.sync_first  = pins;
    state_next.sync_second = state_reg.sync_first;
    if (state_reg.tick_count >= TICK_CYCLES - 17'h00001)
    begin
      state_next.tick_count = `TICK_CNT_RST;
      state_next.tick       = 1'b1;
    end
    else
    begin
      state_next.tick_count = state_reg.tick_count + 17'h00001;
      state_next.tick       = 1'b0;
    end
    state_next.seal   = settings.latch_current_check_en && active && supervision_ok;
    state_next.retrip = active;
    if (block)
      state_next.trip = 1'b0;
    else if (trip_cause)
      state_next.trip = 1'b1;
    else if (hold_done)
      state_next.trip = 1'b0;
    state_next.target                   = state_next.trip;
    state_next.trip_led                 = state_next.trip;
    state_next.status.initiated         = initiated;
    state_next.status.sealed            = state_reg.seal && !block;
    state_next.status.early_op          = early_op;
    state_next.status.main_op           = main_op;
    state_next.status.slow_op           = slow_op;
    state_next.status.high_level_active = active && high_enabled && !low_switch_done;
    state_next.status.low_level_active  = active && high_enabled && low_switch_done;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '{sync_first: `SYNC_RST, sync_second: `SYNC_RST,
                     tick_count: `TICK_CNT_RST, tick: `FLAG_RST, seal: `FLAG_RST,
                     retrip: `FLAG_RST, trip: `FLAG_RST, target: `FLAG_RST,
                     trip_led: `FLAG_RST, status: '0};
    end
    else
      state_reg <= state_next;
  end

  assign retrip         = state_reg.retrip;
  assign zone_trip      = state_reg.trip;
  assign failure_target = state_reg.target;
  assign trip_indicator = state_reg.trip_led;
  assign status         = state_reg.status;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence start_accepted;
    initiated;
  endsequence

  sequence path_fires;
    trip_cause && !block;
  endsequence

  retrip_at_once_a : assert property (start_accepted |=> retrip)
    else $error("Re-trip did not follow an accepted initiation.");

  block_clears_a : assert property (block ##1 block |=> !retrip && !zone_trip)
    else $error("Outputs stayed active while blocked.");

  current_gate_a : assert property (
    (start_in && settings.initiate_current_check_en && !supervision_ok && !state_reg.seal)
    |-> !initiated)
    else $error("Initiation accepted below supervision level.");

  seal_drop_a : assert property (
    (active && !supervision_ok) |=> !state_reg.seal)
    else $error("Seal held without supervision current.");

  trip_set_a : assert property (path_fires |=> zone_trip ##1 failure_target || !zone_trip)
    else $error("Zone trip missing after a failure path fired.");

  early_disabled_a : assert property (!settings.early_path_en |=> !status.early_op)
    else $error("Disabled early path reported operation.");

  slow_inhibit_a : assert property (out_service |=> !status.slow_op)
    else $error("Slow path operated while out of service.");

  trip_hold_a : assert property (
    (zone_trip && !trip_cause && !hold_done && !block) |=> zone_trip)
    else $error("Zone trip released before the hold period.");

  low_after_delay_a : assert property (status.low_level_active |-> $past(low_switch_done))
    else $error("Low level detector active before its delay.");

  tick_spacing_a : assert property (state_reg.tick |=> !state_reg.tick)
    else $error("Protection tick lasted more than one clock.");

endmodule : breaker_failure_scheme

/* breaker_model.sv */
// Behavioural protected breaker and protection trip source facing the scheme.
`timescale 1ns/100ps
`include "breaker_failure_defines.svh"

module breaker_model
#(
  parameter int OPEN_CYCLES = 6
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Bench commands
  input  wire logic                   protect_trip,
  input  wire logic                   reclose,
  input  wire logic                   stuck_mech,
  input  wire logic                   stuck_arc,
  input  wire logic                   neutral_only,
  input  wire logic [`CURRENT_W-1:0]  fault_amp,
  // Scheme side
  input  wire logic                   retrip,
  output logic                        start,
  output logic                        fast_aux,
  output logic                        normal_aux,
  output breaker_failure_pkg::currents_t currents
);
  logic closed_reg;
  int   wait_reg;
  logic flow;

  // The contacts open a fixed time after a trip, unless the mechanism sticks.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      closed_reg <= 1'b1;
      wait_reg   <= 0;
    end
    else if (reclose)
    begin
      closed_reg <= 1'b1;
      wait_reg   <= 0;
    end
    else if ((protect_trip || retrip) && !stuck_mech && closed_reg)
    begin
      wait_reg <= wait_reg + 1;
      if (wait_reg >= OPEN_CYCLES)
        closed_reg <= 1'b0;
    end
  end

  assign start      = protect_trip;
  assign fast_aux   = closed_reg;
  assign normal_aux = closed_reg;
  // A stuck arc keeps current flowing after the contacts part.
  assign flow       = closed_reg || stuck_arc;
  assign currents.phase_a = (flow && !neutral_only) ? fault_amp : 16'h0000;
  assign currents.phase_b = (flow && !neutral_only) ? fault_amp : 16'h0000;
  assign currents.phase_c = (flow && !neutral_only) ? fault_amp : 16'h0000;
  assign currents.neutral = (flow && neutral_only) ? fault_amp : 16'h0000;
endmodule : breaker_model

/* breaker_failure_scheme_test.sv */
// Self-checking bench for the breaker failure scheme.
`timescale 1ns/100ps

module test_breaker_failure_scheme;
  logic                                  clk;
  logic                                  reset_n;
  breaker_failure_pkg::scheme_settings_t cfg;
  breaker_failure_pkg::currents_t        currents;
  breaker_failure_pkg::scheme_status_t   status;
  logic                                  start, fast_aux, normal_aux, oos, inhibit;
  logic                                  retrip, zone_trip, target, led;
  logic                                  ptrip, reclose, mech, arc, nonly;
  logic [15:0]                           amp;
  int                                    err_count;
  int                                    total_checks;

  breaker_failure_scheme #(.TICK_CYCLES(17'h00004)) dut
  (
    .clk(clk), .reset_n(reset_n), .settings(cfg), .currents(currents),
    .three_pole_start_input(start), .fast_aux_closed(fast_aux),
    .normal_aux_closed(normal_aux), .out_of_service_input(oos),
    .scheme_inhibit_input(inhibit), .retrip(retrip), .zone_trip(zone_trip),
    .failure_target(target), .trip_indicator(led), .status(status)
  );

  breaker_model partner
  (
    .clk(clk), .reset_n(reset_n), .protect_trip(ptrip), .reclose(reclose),
    .stuck_mech(mech), .stuck_arc(arc), .neutral_only(nonly), .fault_amp(amp),
    .retrip(retrip), .start(start), .fast_aux(fast_aux),
    .normal_aux(normal_aux), .currents(currents)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic results();
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic seen, input logic exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic pick(input int sel);
    case (sel)
      0: return retrip;
      1: return zone_trip;
      2: return status.high_level_active;
      default: return status.low_level_active;
    endcase
  endfunction : pick

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic wait_for(input int sel, input logic want, input int max, input string msg);
    int n;
    n = 0;
    while (pick(sel) !== want && n < max)
    begin
      cycles(1);
      n++;
    end
    chk(pick(sel), want, msg);
  endtask : wait_for

  // Every cycle is checked, so a short glitch is caught too.
  task automatic hold_for(input int sel, input logic want, input int n, input string msg);
    repeat (n)
    begin
      cycles(1);
      chk(pick(sel), want, msg);
    end
  endtask : hold_for

  task automatic setup(input logic e, input logic m, input logic s, input logic ic,
                       input logic lc, input breaker_failure_pkg::pole_mode_t pm);
    @(posedge clk);
    cfg.early_path_en             <= e;
    cfg.main_path_en              <= m;
    cfg.slow_path_en              <= s;
    cfg.initiate_current_check_en <= ic;
    cfg.latch_current_check_en    <= lc;
    cfg.failure_pole_mode         <= pm;
  endtask : setup

  task automatic fire(input logic [15:0] a, input logic sm, input logic sa, input logic no);
    @(posedge clk);
    amp   <= a;
    mech  <= sm;
    arc   <= sa;
    nonly <= no;
    ptrip <= 1'b1;
  endtask : fire

  task automatic clean();
    @(posedge clk);
    ptrip   <= 1'b0;
    inhibit <= 1'b1;
    cycles(4);
    chk(retrip | zone_trip | target | led, 1'b0, "outputs not cleared");
    chk(status === '0, 1'b1, "status not cleared");
    @(posedge clk);
    reclose <= 1'b1;
    mech    <= 1'b0;
    arc     <= 1'b0;
    nonly   <= 1'b0;
    @(posedge clk);
    reclose <= 1'b0;
    inhibit <= 1'b0;
    cycles(2);
  endtask : clean

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_initiate();
    setup(0, 0, 0, 1, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h01F4, 1, 0, 0);
    hold_for(0, 0, 10, "low current initiated");
    clean();
    fire(16'h07D0, 1, 0, 0);
    wait_for(0, 1, 6, "no retrip");
    chk(status.initiated, 1'b1, "not initiated");
    clean();
    setup(0, 0, 0, 0, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h0000, 1, 0, 0);
    wait_for(0, 1, 6, "unchecked start refused");
    @(posedge clk);
    cfg.scheme_function_en <= 1'b0;
    wait_for(0, 0, 3, "disabled function kept retrip");
    @(posedge clk);
    cfg.scheme_function_en <= 1'b1;
    clean();
  endtask : s_initiate

  task automatic s_neutral();
    setup(0, 0, 0, 1, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h07D0, 1, 0, 1);
    wait_for(0, 1, 6, "neutral ignored in three pole");
    clean();
    setup(0, 0, 0, 1, 0, breaker_failure_pkg::POLE_SINGLE);
    fire(16'h07D0, 1, 0, 1);
    hold_for(0, 0, 10, "neutral used in single pole");
    clean();
  endtask : s_neutral

  task automatic s_seal(input logic lc);
    setup(0, 0, 0, 1, lc, breaker_failure_pkg::POLE_THREE);
    fire(16'h07D0, 1, 0, 0);
    wait_for(0, 1, 6, "no retrip");
    @(posedge clk);
    ptrip <= 1'b0;
    if (lc)
    begin
      hold_for(0, 1, 10, "seal lost");
      chk(status.sealed, 1'b1, "not sealed");
      @(posedge clk);
      amp <= 16'h0000;
    end
    wait_for(0, 0, 6, "retrip stuck");
    clean();
  endtask : s_seal

  // Main delay exceeds early delay, slow delay exceeds main delay.
  task automatic s_main();
    setup(0, 1, 0, 1, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h07D0, 0, 1, 0);
    hold_for(1, 0, 12, "early zone trip");
    wait_for(1, 1, 40, "no zone trip");
    chk(target & led & status.main_op, 1'b1, "indications");
    chk(status.high_level_active, 1'b1, "high detector off");
    chk(status.low_level_active, 1'b0, "low detector early");
    wait_for(3, 1, 16, "low detector never");
    @(posedge clk);
    ptrip <= 1'b0;
    amp   <= 16'h0000;
    hold_for(1, 1, 8, "trip dropped early");
    wait_for(1, 0, 40, "trip never released");
    clean();
  endtask : s_main

  task automatic s_early();
    setup(1, 0, 0, 1, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h07D0, 0, 1, 0);
    hold_for(1, 0, 50, "trip with contact open");
    clean();
    fire(16'h07D0, 1, 0, 0);
    wait_for(1, 1, 40, "early path silent");
    chk(status.early_op, 1'b1, "early status");
    clean();
    setup(0, 0, 0, 1, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h07D0, 1, 0, 0);
    hold_for(1, 0, 60, "disabled path tripped");
    clean();
  endtask : s_early

  task automatic s_slow();
    setup(0, 0, 1, 0, 0, breaker_failure_pkg::POLE_THREE);
    fire(16'h0000, 1, 0, 0);
    wait_for(1, 1, 60, "slow path silent");
    chk(status.slow_op, 1'b1, "slow status");
    clean();
    @(posedge clk);
    oos <= 1'b1;
    fire(16'h0000, 1, 0, 0);
    hold_for(1, 0, 60, "out of service tripped");
    clean();
    @(posedge clk);
    oos <= 1'b0;
  endtask : s_slow

  // ****************************************
  // Run
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200us;
    err_count++;
    results();
  end

  initial
  begin
    err_count    = 0;
    total_checks = 0;
    reset_n = 1'b0;
    cfg = '0;
    cfg.scheme_function_en        = 1'b1;
    cfg.phase_supervision_level   = 15'h03E8;
    cfg.neutral_supervision_level = 15'h03E8;
    cfg.phase_high_level          = 15'h05DC;
    cfg.neutral_high_level        = 15'h05DC;
    cfg.phase_low_level           = 15'h0320;
    cfg.neutral_low_level         = 15'h0320;
    cfg.early_path_delay          = 16'h0003;
    cfg.main_path_delay           = 16'h0005;
    cfg.slow_path_delay           = 16'h0008;
    cfg.low_level_switch_delay    = 16'h0002;
    cfg.trip_hold_period          = 16'h0004;
    {oos, inhibit, ptrip, reclose, mech, arc, nonly} = '0;
    amp = 16'h0000;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    cycles(4);
    s_initiate();
    s_neutral();
    s_seal(1'b0);
    s_seal(1'b1);
    s_main();
    s_early();
    s_slow();
    results();
  end
endmodule : test_breaker_failure_scheme
